// ---- src/ppc_regs.vh ----
`ifndef PPC_REGS_VH
`define PPC_REGS_VH

`define PPC_OFF_DATA       8'h00
`define PPC_OFF_DIR        8'h04
`define PPC_OFF_PULL       8'h08
`define PPC_OFF_SLEW       8'h0c
`define PPC_OFF_DRIVE      8'h10
`define PPC_OFF_SC         8'h14
`define PPC_OFF_PSEL       8'h18
`define PPC_OFF_EDGE       8'h1c
`define PPC_ADDR_W         8

`define PPC_SC_IF          3
`define PPC_SC_ACK         2
`define PPC_SC_IE          1
`define PPC_SC_MOD         0

`define PPC_RST_BYTE       8'h00
`define PPC_RST_SLEW       8'h00

`endif

// ---- src/ppc_detect.v ----
`timescale 1ns/10ps
// Per-pin interrupt detection: asserted-level and edge terms for the enabled pins.
module ppc_detect (
  // Clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // Pin state and configuration
  input  wire [7:0] pin_in,
  input  wire [7:0] irq_pin_select_bits,
  input  wire [7:0] edge_polarity_bits,
  input  wire       detect_mode_select,
  // Detection results
  output wire       irq_event,
  output wire       any_asserted
);

  reg  [7:0] prev_reg;
  reg  [7:0] armed_reg;
  wire [7:0] asserted;
  wire [7:0] edge_hit;

  // A pin counts as asserted when its level matches the chosen polarity.
  assign asserted = ~(pin_in ^ edge_polarity_bits) & irq_pin_select_bits;

  // The edge is a deasserted sample followed by an asserted one, seen while armed.
  assign edge_hit = asserted & ~(prev_reg ^ ~edge_polarity_bits) & armed_reg; // [RULE_13]

  assign irq_event    = (|edge_hit) | (detect_mode_select & (|asserted)); // [RULE_17] [RULE_10]
  assign any_asserted = |asserted;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_reg  <= 8'h00;
      armed_reg <= 8'h00;
    end else begin
      prev_reg  <= pin_in;
      // A pin is armed once it has been seen at its deasserted level.
      armed_reg <= irq_pin_select_bits & (armed_reg | ~asserted); // [RULE_13] [RULE_11]
    end
  end

endmodule

// ---- src/ppc_port.v ----
`timescale 1ns/10ps
`include "ppc_regs.vh"

// Overview of operation
// [RULE_01] Direction bit: 0 input, 1 driven output.
// [RULE_02] Pull enable works only for input pins.
// [RULE_03] Pull-down only on configured interrupt pins.
// [RULE_04] Slew enable applies to output pins only.
// [RULE_05] Software should initialise slew enable after reset.
// [RULE_06] Drive select applies to output pins only.
// [RULE_07] Interrupt flag is read-only, set by hardware.
// [RULE_08] Acknowledge write clears flag, reads zero.
// [RULE_09] Interrupt enable gates the request.
// [RULE_10] Mode bit: edges only, or edges and levels.
// [RULE_11] Pin select enables each interrupt source.
// [RULE_12] Edge select picks polarity and pull type.
// [RULE_13] Edges detected synchronously after deasserted level.
// [RULE_14] Level mode: acknowledge needs all pins deasserted.
// [RULE_15] Data writes latch; outputs drive latched value.
// [RULE_16] Reset clears latch, all pins undriven inputs.
// [RULE_17] Matching condition on enabled pin sets flag.
// [RULE_18] Request equals flag AND enable each cycle.
module ppc_port (
  // AHB-Lite clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Port pins
  input  wire [7:0]  pin_in,
  output wire [7:0]  pin_out,
  output wire [7:0]  pin_oe,
  // Pad controls
  output wire [7:0]  pull_on,
  output wire [7:0]  pull_down,
  output wire [7:0]  slew_on,
  output wire [7:0]  drive_high,
  // Interrupt request
  output wire        irq
);

  reg  [7:0]  port_data_latch_reg;
  reg  [7:0]  direction_bits_reg;
  reg  [7:0]  pull_enable_bits_reg;
  reg  [7:0]  slew_enable_bits_reg;
  reg  [7:0]  drive_select_bits_reg;
  reg  [7:0]  irq_pin_select_bits_reg;
  reg  [7:0]  edge_polarity_bits_reg;
  reg         pin_irq_flag_reg;
  reg         pin_irq_enable_reg;
  reg         detect_mode_select_reg;
  reg         wr_pend_reg;
  reg  [7:0]  wr_addr_reg;
  reg  [7:0]  rd_byte;
  wire        acc_go;
  wire        rd_after_wr;
  wire        wr_data;
  wire        wr_sc;
  wire        ack_req;
  wire        ack_ok;
  wire        irq_event;
  wire        any_asserted;

  function is_off;
    input [7:0] a;
    input [7:0] off;
    begin
      is_off = (a == off);
    end
  endfunction

  // A read whose address phase meets a pending write waits one cycle, so that it
  // returns the freshly written value instead of the old register contents.
  assign rd_after_wr = wr_pend_reg & hsel & htrans[1] & ~hwrite;
  assign hreadyout   = ~rd_after_wr;
  assign hresp       = 1'b0;
  assign acc_go      = hsel & hready & htrans[1];

  assign pin_oe     = direction_bits_reg; // [RULE_01] [RULE_16]
  assign pin_out    = port_data_latch_reg & direction_bits_reg; // [RULE_15]
  assign pull_on    = pull_enable_bits_reg & ~direction_bits_reg; // [RULE_02]
  assign pull_down  = pull_on & irq_pin_select_bits_reg & edge_polarity_bits_reg; // [RULE_03] [RULE_12]
  assign slew_on    = slew_enable_bits_reg & direction_bits_reg; // [RULE_04]
  assign drive_high = drive_select_bits_reg & direction_bits_reg; // [RULE_06]
  assign irq        = pin_irq_flag_reg & pin_irq_enable_reg; // [RULE_18] [RULE_09]

  assign wr_data = wr_pend_reg;
  assign wr_sc   = wr_pend_reg & is_off(wr_addr_reg, `PPC_OFF_SC);
  assign ack_req = wr_sc & hwdata[`PPC_SC_ACK]; // [RULE_08]
  // In level mode the clear is refused while any enabled pin is still asserted.
  assign ack_ok  = ack_req & ~(detect_mode_select_reg & any_asserted); // [RULE_14]

  ppc_detect u_detect (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .pin_in              (pin_in),
    .irq_pin_select_bits (irq_pin_select_bits_reg),
    .edge_polarity_bits  (edge_polarity_bits_reg),
    .detect_mode_select  (detect_mode_select_reg),
    .irq_event           (irq_event),
    .any_asserted        (any_asserted)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= acc_go & hwrite;
      if (acc_go) begin
        wr_addr_reg <= haddr[7:0];
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_data_latch_reg     <= `PPC_RST_BYTE; // [RULE_16]
      direction_bits_reg      <= `PPC_RST_BYTE;
      pull_enable_bits_reg    <= `PPC_RST_BYTE;
      slew_enable_bits_reg    <= `PPC_RST_SLEW; // [RULE_05]
      drive_select_bits_reg   <= `PPC_RST_BYTE;
      irq_pin_select_bits_reg <= `PPC_RST_BYTE;
      edge_polarity_bits_reg  <= `PPC_RST_BYTE;
      pin_irq_enable_reg      <= 1'b0;
      detect_mode_select_reg  <= 1'b0;
    end else if (wr_data) begin
      if (is_off(wr_addr_reg, `PPC_OFF_DATA)) begin
        port_data_latch_reg <= hwdata[7:0]; // [RULE_15]
      end else if (is_off(wr_addr_reg, `PPC_OFF_DIR)) begin
        direction_bits_reg <= hwdata[7:0];
      end else if (is_off(wr_addr_reg, `PPC_OFF_PULL)) begin
        pull_enable_bits_reg <= hwdata[7:0];
      end else if (is_off(wr_addr_reg, `PPC_OFF_SLEW)) begin
        slew_enable_bits_reg <= hwdata[7:0];
      end else if (is_off(wr_addr_reg, `PPC_OFF_DRIVE)) begin
        drive_select_bits_reg <= hwdata[7:0];
      end else if (is_off(wr_addr_reg, `PPC_OFF_SC)) begin
        pin_irq_enable_reg     <= hwdata[`PPC_SC_IE];
        detect_mode_select_reg <= hwdata[`PPC_SC_MOD];
      end else if (is_off(wr_addr_reg, `PPC_OFF_PSEL)) begin
        irq_pin_select_bits_reg <= hwdata[7:0];
      end else if (is_off(wr_addr_reg, `PPC_OFF_EDGE)) begin
        edge_polarity_bits_reg <= hwdata[7:0];
      end
    end
  end

  // The flag ignores written data; a new event wins over a same-cycle acknowledge.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_irq_flag_reg <= 1'b0;
    end else if (irq_event) begin
      pin_irq_flag_reg <= 1'b1; // [RULE_17] [RULE_07]
    end else if (ack_ok) begin
      pin_irq_flag_reg <= 1'b0; // [RULE_08] [RULE_14]
    end
  end

  always @* begin
    rd_byte = 8'h00;
    if (is_off(haddr[7:0], `PPC_OFF_DATA)) begin
      rd_byte = (port_data_latch_reg & direction_bits_reg) |
                (pin_in & ~direction_bits_reg); // [RULE_01]
    end else if (is_off(haddr[7:0], `PPC_OFF_DIR)) begin
      rd_byte = direction_bits_reg;
    end else if (is_off(haddr[7:0], `PPC_OFF_PULL)) begin
      rd_byte = pull_enable_bits_reg;
    end else if (is_off(haddr[7:0], `PPC_OFF_SLEW)) begin
      rd_byte = slew_enable_bits_reg;
    end else if (is_off(haddr[7:0], `PPC_OFF_DRIVE)) begin
      rd_byte = drive_select_bits_reg;
    end else if (is_off(haddr[7:0], `PPC_OFF_SC)) begin
      rd_byte = {4'h0, pin_irq_flag_reg, 1'b0, pin_irq_enable_reg,
                 detect_mode_select_reg}; // [RULE_08] [RULE_07]
    end else if (is_off(haddr[7:0], `PPC_OFF_PSEL)) begin
      rd_byte = irq_pin_select_bits_reg;
    end else if (is_off(haddr[7:0], `PPC_OFF_EDGE)) begin
      rd_byte = edge_polarity_bits_reg;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (acc_go & ~hwrite) begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

endmodule

// ---- verif/ppc_port_checker.sv ----
`timescale 1ns/10ps
module ppc_port_checker (
  // Bus
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  // Pads and request
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  input wire [7:0] pull_on,
  input wire [7:0] pull_down,
  input wire [7:0] slew_on,
  input wire [7:0] drive_high,
  input wire irq
);
  // High in the data phase of a read of the status and control word.
  reg rd_sc;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn) rd_sc <= 1'b0;
    else rd_sc <= hsel & hready & htrans[1] & ~hwrite & (haddr[7:0] == 8'h14);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_out; (pin_out & ~pin_oe) == 8'h00; endproperty
  a_out: assert property (p_out) else $error("input pin driven");
  property p_pull; (pull_on & pin_oe) == 8'h00; endproperty
  a_pull: assert property (p_pull) else $error("pull on output");
  property p_down; (pull_down & ~pull_on) == 8'h00; endproperty
  a_down: assert property (p_down) else $error("pull-down without pull");
  property p_slew; (slew_on & ~pin_oe) == 8'h00; endproperty
  a_slew: assert property (p_slew) else $error("slew on input");
  property p_drive; (drive_high & ~pin_oe) == 8'h00; endproperty
  a_drive: assert property (p_drive) else $error("drive on input");
  property p_ack; rd_sc |-> hrdata[2] == 1'b0; endproperty
  a_ack: assert property (p_ack) else $error("ack bit read as one");
  property p_irq; rd_sc |-> (hrdata[3] & hrdata[1]) == $past(irq); endproperty
  a_irq: assert property (p_irq) else $error("request not flag and enable");
  property p_rst; $rose(hresetn) |-> (pin_oe == 8'h00 && pull_on == 8'h00 && !irq) [*2]; endproperty
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
endmodule

bind ppc_port ppc_port_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hrdata, .pin_out, .pin_oe, .pull_on, .pull_down, .slew_on, .drive_high, .irq);

// ---- verif/ppc_pins_model.sv ----
`timescale 1ns/10ps
module ppc_pins_model (
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  input wire [7:0] ext_val,
  output wire [7:0] pin_in
);
  // The outside circuit drives every pin that the port leaves as an input.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/10ps
module tb;
  reg hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  reg [1:0] htrans = 2'b00;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h14828756, rnd, rd, e;
  reg [7:0] ext_val = 8'h00;
  wire hready, hresp, irq;
  wire [31:0] hrdata;
  wire [7:0] pin_in, pin_out, pin_oe, pull_on, pull_down, slew_on, drive_high;
  integer n_mismatch = 0, check_count = 0, i, j, k, t;
  always #25 hclk = ~hclk;
  ppc_port dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready, .hreadyout(hready), .hresp, .hrdata, .pin_in, .pin_out, .pin_oe, .pull_on,
    .pull_down, .slew_on, .drive_high, .irq);
  ppc_pins_model u_pins (.pin_out, .pin_oe, .ext_val, .pin_in);
  function [31:0] xs(input [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction
  task chk(input [39:0] seen, input [39:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task xfer(input w, input [7:0] a, input [7:0] d);
    {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, a, 2'b10, w};
    for (k = 0; k < 2; k = k + 1) begin
      @(posedge hclk);
      for (t = 0; hready !== 1'b1; t = t + 1) begin
        if (t == 9) begin
          n_mismatch = n_mismatch + 1;
          wrap_up;
        end
        @(posedge hclk);
      end
      if (k == 0) {htrans, hwdata} <= {2'b00, 24'h0, d};
    end
    rd = hrdata;
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    ext_val <= 8'h5a;
    for (i = 0; i < 9; i = i + 1) begin
      xfer(1'b0, 8'(4 * i), 8'h00);
      chk({hresp, rd}, {1'b0, i ? 32'h0 : 32'h5a});
    end
    for (i = 0; i < 24; i = i + 1) begin
      rnd = (i == 0) ? 32'hffff00ff : (i == 1) ? 32'hffffff00 : xs(seed);
      seed = xs(rnd);
      ext_val <= seed[15:8];
      for (j = 0; j < 5; j = j + 1)
        xfer(1'b1, 8'(4 * j), j ? 8'(rnd >> (8 * j - 8)) : seed[7:0]);
      for (j = 0; j < 5; j = j + 1) begin
        xfer(1'b0, 8'(4 * j), 8'h00);
        e = j ? 8'(rnd >> (8 * j - 8)) : seed[7:0] & rnd[7:0] | seed[15:8] & ~rnd[7:0];
        chk(rd, e);
      end
      e = {rnd[7:0], seed[7:0] & rnd[7:0], rnd[15:8] & ~rnd[7:0], 8'h00};
      chk({pin_oe, pin_out, pull_on, pull_down}, e);
      chk({slew_on, drive_high}, {rnd[23:16] & rnd[7:0], rnd[31:24] & rnd[7:0]});
    end
    ext_val <= 8'h00;
    for (i = 0; i < 5; i = i + 1)
      xfer(1'b1, 8'(40'h04_1c_08_18_14 >> (32 - 8 * i)), 8'(40'h00_01_01_01_06 >> (32 - 8 * i)));
    chk(pull_down, 8'h01);
    ext_val <= 8'h01;
    // Bit 7 of each expected byte stands for the request line.
    // The level-mode flag is set one edge after the mode write, so the read right
    // after it still shows a clear flag while the request line already stands.
    for (i = 0; i < 6; i = i + 1) begin
      if (i == 5) ext_val <= 8'h00;
      xfer(1'b1, 8'h14, 8'(48'h02_08_0c_07_07_07 >> (40 - 8 * i)));
      xfer(1'b0, 8'h14, 8'h00);
      e = 8'(48'h8a_08_00_83_8b_03 >> (40 - 8 * i));
      chk({rd[31:8], irq, rd[6:0]}, e);
    end
    wrap_up;
  end
endmodule
